//--- verilog/serial_config_loader.sv
// serial configuration loader with daisy-chain pass-through, plus its byte fifo
// assumes link pins arrive asynchronously and the link clock is far slower than sys_clk
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module cfg_byte_fifo
	import cfg_loader_pkg::*;
#(
	parameter int W = FIFO_W,
	parameter int D = FIFO_D
) (
	// clock
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
	} fifo_state_t;
	fifo_state_t q, d;
	logic full, empty;

	assign empty = (q.wr == q.rd);
	assign full = (q.wr[AW-1:0] == q.rd[AW-1:0]) && (q.wr[AW] != q.rd[AW]);
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign out_data = q.mem[q.rd[AW-1:0]];

	always_comb begin
		d = q;
		if (in_valid && !full) begin
			d.mem[q.wr[AW-1:0]] = in_data;
			d.wr = q.wr + 1'b1;
		end
		if (out_ready && !empty) begin
			d.rd = q.rd + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= '0;
		end else if (clk_en) begin
			q <= d;
		end
	end
endmodule // cfg_byte_fifo

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - sample three mode pins; all high selects slave
// - sample modes two clocks after init high
// - on preamble 0010 capture length count
// - after length, hold pass-through output high
// - after own frames, forward data unchanged
// - count clocks; length match starts start-up
// - release user io two clocks after match
// - frame: start bit, data, four check bits
// - frame count from column count formula
// - program data is frames plus postamble
// - leading and trailing one dummies counted
// - keep counting trailing clocks to finish point
// - unfinished device refuses readback and scan
// - after load, mode pins become user io
// - check failure stops loading, drives init low
module serial_config_loader
	import cfg_loader_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// serial link
	input wire logic config_bit_clock,
	input wire logic din,
	output logic dout,
	// init status pin, open drain
	input wire logic init_n,
	output logic init_out,
	output logic init_oe,
	// mode pins
	input wire logic mode_select_pin_2,
	input wire logic mode_select_pin_1,
	input wire logic mode_select_pin_0,
	output logic mode_1_out,
	output logic mode_1_oe,
	// options and user side of mode pins
	input wire logic check_en,
	input wire logic user_mode_1,
	output logic [1:0] user_mode_in,
	output logic [2:0] sampled_mode,
	// status
	output logic high_during_cfg,
	output logic low_during_cfg_n,
	output logic done,
	output logic io_active,
	output logic finished,
	output logic readback_allow,
	output logic scan_allow,
	output logic cfg_error,
	output logic load_stall,
	// configuration bytes
	output logic cfg_byte_valid,
	output logic [FIFO_W-1:0] cfg_byte,
	input wire logic cfg_byte_ready
);
	typedef struct packed {
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic config_bit_clock_prev;
		load_st_t st;
		logic [1:0] wait_cnt;
		logic [2:0] mode;
		logic [3:0] pre;
		logic [4:0] len_cnt;
		logic [23:0] len;
		logic len_ok;
		logic [7:0] bit_cnt;
		logic [9:0] frame_cnt;
		logic [3:0] chk;
		logic [7:0] byte_sh;
		logic [2:0] byte_n;
		logic [7:0] byte_q;
		logic push;
		logic [23:0] clk_cnt;
		logic matched;
		logic [2:0] post;
		logic dout;
		logic init_oe;
		logic hdc;
		logic ldc_n;
		logic done;
		logic io_en;
		logic finished;
		logic [1:0] user_in;
		logic m1_out;
		logic stall;
	} ld_state_t;
	ld_state_t q, d;
	logic fifo_in_ready;
	logic rise, bit_in, init_hi, loading;
	logic [3:0] pre_next;
	logic [1:0] chk_idx;

	cfg_byte_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.in_valid(q.push),
		.in_data(q.byte_q),
		.in_ready(fifo_in_ready),
		.out_valid(cfg_byte_valid),
		.out_data(cfg_byte),
		.out_ready(cfg_byte_ready)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.push = 1'b0;
		// pins pass two flops; only sync2 is read below
		d.sync1 = {config_bit_clock, din, init_n,
			mode_select_pin_2, mode_select_pin_1, mode_select_pin_0};
		d.sync2 = q.sync1;
		d.config_bit_clock_prev = q.sync2[5];
		d.stall = ~fifo_in_ready;
		rise = q.sync2[5] & ~q.config_bit_clock_prev;
		bit_in = q.sync2[4];
		init_hi = q.sync2[3];
		pre_next = {q.pre[2:0], bit_in};
		chk_idx = 2'(q.bit_cnt - CHECK_FIRST);
		loading = (q.st == ST_PRE) || (q.st == ST_LEN) ||
			(q.st == ST_FRAME) || (q.st == ST_PASS);
		case (q.st)
			ST_WAIT: begin
				if (init_hi) begin
					d.wait_cnt = q.wait_cnt + 2'h1;
					// two clocks after init seen high
					if (q.wait_cnt == INIT_SAMPLE_CLKS) begin
						d.mode = q.sync2[2:0];
						if (q.sync2[2:0] == MODE_SLAVE_SERIAL) begin
							d.st = ST_PRE;
						end else begin
							d.st = ST_OTHER;
						end
					end
				end else begin
					d.wait_cnt = 2'h0;
				end
			end
			ST_PRE: begin
				if (rise) begin
					d.pre = pre_next;
					d.dout = bit_in;
					if (pre_next == PREAMBLE) begin
						d.st = ST_LEN;
						d.len_cnt = 5'h0;
					end
				end
			end
			ST_LEN: begin
				if (rise) begin
					d.dout = bit_in;
					d.len = {q.len[22:0], bit_in};
					d.len_cnt = q.len_cnt + 5'h1;
					if (q.len_cnt == LEN_LAST) begin
						d.st = ST_FRAME;
						d.len_ok = 1'b1;
						d.bit_cnt = 8'h0;
						d.frame_cnt = 10'h0;
					end
				end
			end
			ST_FRAME: begin
				if (rise) begin
					// downstream sees ones while own frames load
					d.dout = 1'b1;
					if (q.bit_cnt == 8'h0) begin
						// ones before the first start bit are dummies; later ones are errors when checks are on
						if (!bit_in) begin
							d.bit_cnt = 8'h1;
							d.chk = 4'h0;
						end else if (check_en && q.frame_cnt != 10'h0) begin
							d.st = ST_ERR;
						end
					end else if (q.bit_cnt <= DATA_LAST) begin
						// data bits, folded into four check lanes
						d.chk[q.bit_cnt[1:0]] = q.chk[q.bit_cnt[1:0]] ^ bit_in;
						d.bit_cnt = q.bit_cnt + 8'h1;
						d.byte_sh = {q.byte_sh[6:0], bit_in};
						d.byte_n = q.byte_n + 3'h1;
						if (q.byte_n == 3'h7) begin
							d.byte_q = {q.byte_sh[6:0], bit_in};
							d.push = 1'b1;
							// link cannot be stalled, so overrun is an error
							if (!fifo_in_ready) begin
								d.st = ST_ERR;
							end
						end
					end else begin
						d.bit_cnt = q.bit_cnt + 8'h1;
						if (check_en && (bit_in != q.chk[chk_idx])) begin
							d.st = ST_ERR;
						end else if (chk_idx == 2'h3) begin
							d.bit_cnt = 8'h0;
							d.frame_cnt = q.frame_cnt + 10'h1;
							if (q.frame_cnt == FRAME_LAST) begin
								d.st = ST_PASS;
							end
						end
					end
				end
			end
			ST_PASS: begin
				if (rise) begin
					d.dout = bit_in;
				end
			end
			ST_ERR: begin
				d.init_oe = 1'b1;
			end
			ST_OTHER: begin
				d.dout = 1'b1;
			end
			default: begin
				d.st = ST_ERR;
			end
		endcase
		// count link clocks; match starts start-up
		if (rise && loading && !q.matched && d.st != ST_ERR) begin
			d.clk_cnt = q.clk_cnt + 24'h1;
			if (q.len_ok && (q.clk_cnt + 24'h1 == q.len)) begin
				d.matched = 1'b1;
			end
		end
		// keep counting trailing clocks after match
		// an error after the match must never release the io
		if (rise && q.matched && q.post != FINISH_CCLKS && d.st != ST_ERR) begin
			d.post = q.post + 3'h1;
			// io released two clocks after last bit
			if (q.post + 3'h1 == IO_RELEASE_CCLKS) begin
				d.io_en = 1'b1;
				d.done = 1'b1;
				d.hdc = 1'b0;
				d.ldc_n = 1'b1;
			end
			// finish point four clocks after match
			if (q.post + 3'h1 == FINISH_CCLKS) begin
				d.finished = 1'b1;
			end
		end
		// mode pins become user io after load
		if (q.io_en) begin
			d.user_in = {q.sync2[2], q.sync2[0]};
			d.m1_out = user_mode_1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= '0;
			q.st <= ST_WAIT;
			q.dout <= 1'b1;
			q.hdc <= 1'b1;
			// idle line is high; zeros here would fake an early preamble
			q.pre <= 4'hf;
		end else if (clk_en) begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign dout = q.dout;
	// open drain: only ever drives low
	assign init_out = q.ldc_n & ~q.ldc_n;
	assign init_oe = q.init_oe;
	assign mode_1_out = q.m1_out;
	assign mode_1_oe = q.io_en;
	assign user_mode_in = q.user_in;
	assign sampled_mode = q.mode;
	assign high_during_cfg = q.hdc;
	assign low_during_cfg_n = q.ldc_n;
	assign done = q.done;
	assign io_active = q.io_en;
	assign finished = q.finished;
	// readback and scan gated by finish point
	assign readback_allow = q.finished;
	assign scan_allow = q.finished;
	assign cfg_error = q.init_oe;
	assign load_stall = q.stall;
endmodule // serial_config_loader

//--- include/cfg_loader_pkg.sv
// constants for the serial configuration loader and its byte fifo
// assumes one 40 MHz system clock; link pins are asynchronous to it
package cfg_loader_pkg;
	// array geometry of the loaded device
	localparam int ARRAY_ROWS = 16;
	localparam int ARRAY_COLS = 16;
	localparam int FRAME_BITS = (10 * ARRAY_ROWS) + 7 + 13 + 1 + 1 + 4;
	localparam int FRAME_COUNT = (36 * ARRAY_COLS) + 26 + 41 + 1;
	localparam int POSTAMBLE_BITS = 8;
	localparam int CHECK_BITS = 4;
	// last data bit index inside a frame (start bit is index 0)
	localparam logic [7:0] DATA_LAST = 8'(FRAME_BITS - CHECK_BITS - 1);
	localparam logic [7:0] CHECK_FIRST = 8'(FRAME_BITS - CHECK_BITS);
	localparam logic [9:0] FRAME_LAST = 10'(FRAME_COUNT - 1);
	// stream framing
	localparam logic [3:0] PREAMBLE = 4'h2;
	localparam logic [4:0] LEN_LAST = 5'h17;
	localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h7;
	// timing counts
	localparam logic [1:0] INIT_SAMPLE_CLKS = 2'h2;
	localparam logic [2:0] IO_RELEASE_CCLKS = 3'h2;
	localparam logic [2:0] FINISH_CCLKS = 3'h4;
	// byte fifo shape
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 8;
	typedef enum logic [7:0] {
		ST_WAIT = 8'h01,
		ST_PRE = 8'h02,
		ST_LEN = 8'h04,
		ST_FRAME = 8'h08,
		ST_PASS = 8'h10,
		ST_ERR = 8'h20,
		ST_OTHER = 8'h40
	} load_st_t;
endpackage

//--- verif/cfg_loader_chk_asserts.sv
// checker on the loader status, init and mode pin outputs
// assumes one sys_clk domain and bind onto serial_config_loader
`timescale 1ns/10ps
module cfg_loader_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// watched outputs
	input wire logic dout,
	input wire logic init_out,
	input wire logic init_oe,
	input wire logic mode_1_oe,
	input wire logic [1:0] user_mode_in,
	input wire logic high_during_cfg,
	input wire logic low_during_cfg_n,
	input wire logic done,
	input wire logic io_active,
	input wire logic finished,
	input wire logic readback_allow,
	input wire logic scan_allow,
	input wire logic cfg_error
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	AST_DONE_IO: assert property (done == io_active) else $error("done off");
	AST_HDC: assert property (high_during_cfg != io_active) else $error("hdc off");
	AST_LDC: assert property (low_during_cfg_n == io_active) else $error("ldc off");
	AST_ALLOW: assert property ((readback_allow & scan_allow) == finished)
		else $error("allow off");
	AST_FIN: assert property ($rose(finished) |-> $past(io_active, 4))
		else $error("finish early");
	AST_ERR_HOLD: assert property (cfg_error |=> cfg_error) else $error("error lost");
	AST_INIT_PULL: assert property ($rose(init_oe) |-> init_out == 1'h0 ##[0:1] cfg_error)
		else $error("init pull");
	AST_NO_START: assert property (cfg_error |-> !$rose(io_active))
		else $error("start after error");
	AST_M1_OE: assert property ($rose(io_active) |-> ##[0:1] mode_1_oe)
		else $error("mode out");
	AST_UIN: assert property (!io_active |-> user_mode_in == 2'h0)
		else $error("user in early");
	AST_DOUT_RST: assert property ($rose(rst_n) |-> dout) else $error("dout reset");
endmodule // cfg_loader_chk
bind serial_config_loader cfg_loader_chk cfg_loader_chk_inst (.*);

//--- verif/cfg_src_model.sv
// serial configuration source driving link clock and data
// assumes 200 ns link period; clock parked low between bits
`timescale 1ns/10ps
module cfg_src_model (
	// serial link
	output logic config_bit_clock,
	output logic din
);
	initial begin
		config_bit_clock = 1'h0;
		din = 1'h1;
	end
	// no test port driven here; nothing toggles it while loading
	// set up before rise, one bit a clock
	task automatic send(input logic b);
		din = b;
		#100;
		config_bit_clock = 1'h1;
		#50;
		// hold over; show the inverse, not a stale copy
		din = ~b;
		#50;
		config_bit_clock = 1'h0;
	endtask
endmodule // cfg_src_model

//--- verif/tb_serial_config_loader.sv
// bench for the serial configuration loader
// assumes cfg_loader_pkg compiled first; source model drives the link
`timescale 1ns/10ps
module tb_serial_config_loader;
	import cfg_loader_pkg::*;
	logic sys_clk = 1'h0;
	logic rst_n, clk_en, init_n, check_en, user_mode_1, hold_ready, cfg_byte_ready = 1'h0;
	logic mode_select_pin_2, mode_select_pin_1, mode_select_pin_0;
	logic config_bit_clock, din, dout, init_out, init_oe, mode_1_out, mode_1_oe;
	logic [1:0] user_mode_in;
	logic [2:0] sampled_mode;
	logic high_during_cfg, low_during_cfg_n, done, io_active, finished;
	logic readback_allow, scan_allow, cfg_error, load_stall, cfg_byte_valid;
	logic [FIFO_W-1:0] cfg_byte;
	logic [7:0] got[$];
	logic exp_bits[$];
	logic pop_ok;
	int err_total = 0;
	int checks = 0;
	cfg_src_model cfg_src_model_inst (.*);
	serial_config_loader serial_config_loader_inst (.*);
	always #12.5 sys_clk = ~sys_clk;
	// stalls drain side at random
	// pop is logged off the edge: fifo head is settled until the next rise
	always @(negedge sys_clk) begin
		pop_ok = !hold_ready && ($urandom_range(3) != 0);
		cfg_byte_ready <= pop_ok;
		if (cfg_byte_valid === 1'h1 && pop_ok) got.push_back(cfg_byte);
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	function automatic logic [7:0] exp_byte(input int n);
		for (int j = 0; j < 8; j++) exp_byte[7 - j] = exp_bits[8 * n + j];
	endfunction
	task automatic sb(input logic b, input logic ck, input logic e);
		cfg_src_model_inst.send(b);
		if (ck) begin
			cyc(2);
			chk("dout", dout, e);
		end
	endtask
	task automatic start(input logic [2:0] md);
		cyc(1);
		rst_n = 1'h0;
		init_n = 1'h0;
		{mode_select_pin_2, mode_select_pin_1, mode_select_pin_0} = md;
		cyc(5);
		rst_n = 1'h1;
		cyc(2);
		init_n = 1'h1;
		cyc(8);
		chk("sampled_mode", sampled_mode, md);
		got.delete();
		exp_bits.delete();
	endtask
	task automatic hdr(input logic [23:0] len);
		sb(1'h1, 1'h0, 1'h0);
		sb(1'h1, 1'h0, 1'h0);
		for (int i = 3; i >= 0; i--) sb(PREAMBLE[i], 1'h1, PREAMBLE[i]);
		for (int i = 23; i >= 0; i--) sb(len[i], 1'h1, len[i]);
	endtask
	// start bit, random data, four check lanes
	task automatic frame(input logic bad);
		logic [3:0] lane;
		logic b;
		lane = 4'h0;
		sb(1'h0, 1'h1, 1'h1);
		for (int i = 1; i < CHECK_FIRST; i++) begin
			b = 1'($urandom);
			lane[i % 4] ^= b;
			exp_bits.push_back(b);
			sb(b, i < 3, 1'h1);
		end
		for (int k = 0; k < 4; k++) sb(lane[k] ^ (bad && k == 2), 1'h0, 1'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h3137));
		rst_n = 1'h0;
		clk_en = 1'h1;
		check_en = 1'h1;
		user_mode_1 = 1'h0;
		hold_ready = 1'h0;
		start(3'($urandom_range(6)));
		repeat (40) sb(1'($urandom), 1'h0, 1'h0);
		cyc(2);
		chk("dout", dout, 1'h1);
		chk("bytes", got.size(), 0);
		$display("test refused mode done");
		start(MODE_SLAVE_SERIAL);
		hdr(24'h00_00db);
		frame(1'h0);
		sb(1'h0, 1'h1, 1'h1);
		sb(1'h1, 1'h0, 1'h0);
		sb(1'h1, 1'h0, 1'h0);
		for (int e = 1; e <= 4; e++) begin
			sb(1'h1, 1'h0, 1'h0);
			cyc(2);
			chk("io_active", io_active, e >= 2);
			chk("done", done, e >= 2);
			chk("high_during_cfg", high_during_cfg, e < 2);
			chk("low_during_cfg_n", low_during_cfg_n, e >= 2);
			chk("finished", finished, e >= 4);
		end
		chk("byte_count", got.size() >= 22, 1'h1);
		for (int n = 0; n < 22; n++) chk("cfg_byte", got[n], exp_byte(n));
		{mode_select_pin_2, mode_select_pin_0} = 2'($urandom);
		user_mode_1 = 1'h1;
		cyc(6);
		chk("user_mode_in", user_mode_in, {mode_select_pin_2, mode_select_pin_0});
		chk("mode_1_out", mode_1_out, 1'h1);
		chk("allow", readback_allow & scan_allow, 1'h1);
		clk_en = 1'h0;
		user_mode_1 = 1'h0;
		cyc(6);
		chk("frozen_mode_1_out", mode_1_out, 1'h1);
		clk_en = 1'h1;
		cyc(6);
		chk("mode_1_out_low", mode_1_out, 1'h0);
		$display("test full load done");
		hold_ready = 1'h1;
		start(MODE_SLAVE_SERIAL);
		hdr(24'h00_00db);
		frame(1'h0);
		chk("load_stall", load_stall, 1'h1);
		chk("init_oe", init_oe, 1'h1);
		hold_ready = 1'h0;
		repeat (7) sb(1'h1, 1'h0, 1'h0);
		cyc(4);
		chk("drained", {cfg_byte_valid, got.size() == FIFO_D}, 2'h1);
		chk("done", done, 1'h0);
		$display("test overrun done");
		check_en = 1'h0;
		start(MODE_SLAVE_SERIAL);
		hdr(24'hff_ffff);
		frame(1'h1);
		sb(1'h1, 1'h0, 1'h0);
		cyc(4);
		chk("dummy_ok", cfg_error, 1'h0);
		check_en = 1'h1;
		frame(1'h1);
		cyc(4);
		chk("bad_check", {cfg_error, init_oe}, 2'h3);
		$display("test check lanes done");
		test_done();
	end
	initial begin
		#1000000;
		err_total++;
		test_done();
	end
endmodule // tb_serial_config_loader
